/* verilog/io_alu_defines.vh */
// Purpose: Constants for the port-read, calculate and compare unit
// Assumes: Included by both design files
// Notes: Definitions only
`ifndef IO_ALU_DEFINES_VH
`define IO_ALU_DEFINES_VH
`define OPC_PORT_READ 8'h0f
`define OPC_CALCULATE 8'h13
`define OPC_COMPARE 8'h14
`define BANK_DIGITAL_IN 8'h00
`define BANK_ANALOG 8'h01
`define BANK_OUTPUT_STATE 8'h02
`define PORT_ALL_INPUTS 8'hff
`define PORT_ANALOG_ZERO 8'h00
`define PORT_ANALOG_FOUR 8'h04
`define PORT_SUPPLY 8'h08
`define PORT_TEMP_A 8'h09
`define PORT_TEMP_B 8'h0a
`define PORT_TEMP_C 8'h0b
`define PORT_LAST_LINE 8'h07
`define OP_ADD 8'h00
`define OP_SUB 8'h01
`define OP_MUL 8'h02
`define OP_DIV 8'h03
`define OP_MOD 8'h04
`define OP_AND 8'h05
`define OP_OR 8'h06
`define OP_XOR 8'h07
`define OP_NOT 8'h08
`define OP_LOAD 8'h09
`define STATUS_OK 8'h64
`define STATUS_BAD_CMD 8'h02
`define ACC_RESET 32'h00000000
`define ZERO_WORD 32'h00000000
`endif

/* verilog/calculate_instruction_unit.v */
// Purpose: Combinational 32-bit accumulator arithmetic
// Assumes: Signed two's-complement operands
// Notes: Division by zero yields zero rather than trapping
`timescale 1ns/1ps
`include "io_alu_defines.vh"
module calculate_instruction_unit (
  input wire [7:0] operation,
  input wire [31:0] acc,
  input wire [31:0] operand,
  output reg [31:0] result
);
  wire signed [31:0] sa = acc;
  wire signed [31:0] sb = operand;
  wire [63:0] product = sa * sb;
  // Kept apart: the unsigned zero in the mux would make these unsigned
  wire signed [31:0] quotient = sa / sb;
  wire signed [31:0] remainder = sa % sb;
  wire zero_div = (operand == `ZERO_WORD);
  always @* begin
    case (operation)
      `OP_ADD: result = acc + operand;
      `OP_SUB: result = acc - operand;
      `OP_MUL: result = product[31:0];
      `OP_DIV: result = zero_div ? `ZERO_WORD : quotient;
      `OP_MOD: result = zero_div ? `ZERO_WORD : remainder;
      `OP_AND: result = acc & operand;
      `OP_OR: result = acc | operand;
      `OP_XOR: result = acc ^ operand;
      `OP_NOT: result = ~acc;
      `OP_LOAD: result = operand;
      default: result = acc;
    endcase
  end
endmodule // calculate_instruction_unit

/* verilog/io_read_accumulator_alu.v */
// Purpose: Port-read, calculate and compare instruction executer
// Assumes: Command fields held stable while cmd_valid is high
// Notes: Pins are synchronised; one command per cycle at most
`timescale 1ns/1ps
`include "io_alu_defines.vh"
module io_read_accumulator_alu (
  input wire clk_sys,
  input wire resetn,
  input wire cmd_valid,
  input wire cmd_standalone,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_type,
  input wire [7:0] cmd_bank,
  input wire [31:0] cmd_value,
  input wire [7:0] general_inputs,
  input wire [11:0] analog_capable_input_zero,
  input wire [11:0] analog_capable_input_four,
  input wire [11:0] supply_tenths_volt,
  input wire [11:0] temperature_a,
  input wire [11:0] temperature_b,
  input wire [11:0] temperature_c,
  input wire [7:0] output_states,
  output reg reply_valid,
  output reg [7:0] reply_status,
  output reg [7:0] reply_code,
  output reg [31:0] reply_value,
  output reg [31:0] accumulator,
  output reg flag_zero,
  output reg flag_equal,
  output reg flag_greater,
  output reg flag_lower
);
  reg [7:0] in_meta;
  reg [7:0] in_sync;
  reg [7:0] out_meta;
  reg [7:0] out_sync;
  reg [11:0] an0_meta;
  reg [11:0] an0_sync;
  reg [11:0] an4_meta;
  reg [11:0] an4_sync;
  reg [11:0] sup_meta;
  reg [11:0] sup_sync;
  reg [11:0] ta_meta;
  reg [11:0] ta_sync;
  reg [11:0] tb_meta;
  reg [11:0] tb_sync;
  reg [11:0] tc_meta;
  reg [11:0] tc_sync;
  reg [31:0] read_value;
  reg read_ok;
  wire [31:0] calculate_instruction_result;

  // Pins come from outside; analog words assumed quasi-static per sample
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      in_meta <= 8'h00;
      in_sync <= 8'h00;
      out_meta <= 8'h00;
      out_sync <= 8'h00;
      an0_meta <= 12'h000;
      an0_sync <= 12'h000;
      an4_meta <= 12'h000;
      an4_sync <= 12'h000;
      sup_meta <= 12'h000;
      sup_sync <= 12'h000;
      ta_meta <= 12'h000;
      ta_sync <= 12'h000;
      tb_meta <= 12'h000;
      tb_sync <= 12'h000;
      tc_meta <= 12'h000;
      tc_sync <= 12'h000;
    end else begin
      in_meta <= general_inputs;
      in_sync <= in_meta;
      out_meta <= output_states;
      out_sync <= out_meta;
      an0_meta <= analog_capable_input_zero;
      an0_sync <= an0_meta;
      an4_meta <= analog_capable_input_four;
      an4_sync <= an4_meta;
      sup_meta <= supply_tenths_volt;
      sup_sync <= sup_meta;
      ta_meta <= temperature_a;
      ta_sync <= ta_meta;
      tb_meta <= temperature_b;
      tb_sync <= tb_meta;
      tc_meta <= temperature_c;
      tc_sync <= tc_meta;
    end
  end

  function [31:0] bit_of;
    input [7:0] vec;
    input [7:0] idx;
    begin
      bit_of = {31'h00000000, vec[idx[2:0]]};
    end
  endfunction

  function [31:0] word12;
    input [11:0] v;
    begin
      word12 = {20'h00000, v};
    end
  endfunction

  always @* begin
    read_value = `ZERO_WORD;
    read_ok = 1'b1;
    case (cmd_bank)
      `BANK_DIGITAL_IN: begin
        if (cmd_type == `PORT_ALL_INPUTS)
          read_value = {24'h000000, in_sync};
        else if (cmd_type <= `PORT_LAST_LINE)
          read_value = bit_of(in_sync, cmd_type);
        else
          read_ok = 1'b0;
      end
      `BANK_ANALOG: begin
        case (cmd_type)
          `PORT_ANALOG_ZERO: read_value = word12(an0_sync);
          `PORT_ANALOG_FOUR: read_value = word12(an4_sync);
          `PORT_SUPPLY: read_value = word12(sup_sync);
          `PORT_TEMP_A: read_value = word12(ta_sync);
          `PORT_TEMP_B: read_value = word12(tb_sync);
          `PORT_TEMP_C: read_value = word12(tc_sync);
          default: read_ok = 1'b0;
        endcase
      end
      `BANK_OUTPUT_STATE: begin
        if (cmd_type <= `PORT_LAST_LINE)
          read_value = bit_of(out_sync, cmd_type);
        else
          read_ok = 1'b0;
      end
      default: read_ok = 1'b0;
    endcase
  end

  // signed operand word
  // Operand arrives already assembled, bit 31 is the sign
  calculate_instruction_unit u_calculate_instruction (
    .operation(cmd_type),
    .acc(accumulator),
    .operand(cmd_value),
    .result(calculate_instruction_result)
  );

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reply_valid <= 1'b0;
      reply_status <= 8'h00;
      reply_code <= 8'h00;
      reply_value <= `ZERO_WORD;
      accumulator <= `ACC_RESET;
      flag_zero <= 1'b0;
      flag_equal <= 1'b0;
      flag_greater <= 1'b0;
      flag_lower <= 1'b0;
    end else begin
      // Replies only go to the host
      reply_valid <= cmd_valid && !cmd_standalone;
      if (cmd_valid) begin
        reply_code <= cmd_code;
        reply_status <= `STATUS_OK;
        case (cmd_code)
          `OPC_PORT_READ: begin
            reply_value <= read_value;
            if (!read_ok)
              reply_status <= `STATUS_BAD_CMD;
            if (cmd_standalone && read_ok)
              accumulator <= read_value;
          end
          `OPC_CALCULATE: begin
            reply_value <= cmd_value;
            accumulator <= calculate_instruction_result;
          end
          `OPC_COMPARE: begin
            reply_value <= cmd_value;
            // signed compare; flags cover all jump tests
            flag_equal <= (accumulator == cmd_value);
            flag_zero <= (accumulator == cmd_value);
            flag_greater <= ($signed(accumulator) > $signed(cmd_value));
            flag_lower <= ($signed(accumulator) < $signed(cmd_value));
          end
          default: begin
            reply_value <= `ZERO_WORD;
            reply_status <= `STATUS_BAD_CMD;
          end
        endcase
      end
    end
  end
endmodule // io_read_accumulator_alu

/* verif/host_model.sv */
// Purpose: Host issuing command words
// Assumes: Fields change on falling edges
// Notes: Fields scrambled once the strobe drops
`timescale 1ns/1ps
module host_model (
  input wire clk_sys,
  output reg cmd_valid = 1'b0,
  output reg cmd_standalone = 1'b0,
  output reg [7:0] cmd_code = 8'h00,
  output reg [7:0] cmd_type = 8'h00,
  output reg [7:0] cmd_bank = 8'h00,
  output reg [31:0] cmd_value = 32'h0
);
  task send(input s, input [7:0] c, t, b, input [31:0] v);
    @(negedge clk_sys);
    {cmd_valid, cmd_standalone} = {1'b1, s};
    {cmd_code, cmd_type, cmd_bank, cmd_value} = {c, t, b, v};
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    {cmd_code, cmd_type, cmd_bank, cmd_value} = ~{c, t, b, v};
  endtask
endmodule // host_model

/* verif/io_alu_props.sv */
// Purpose: Timing relations of the port-read unit
// Assumes: Bound to the top module
// Notes: All checks one cycle after a command or an idle cycle
`timescale 1ns/1ps
`include "io_alu_defines.vh"
module io_alu_props (
  input wire clk_sys,
  input wire resetn,
  input wire cmd_valid,
  input wire cmd_standalone,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_type,
  input wire [31:0] cmd_value,
  input wire reply_valid,
  input wire [31:0] reply_value,
  input wire [31:0] accumulator,
  input wire flag_equal,
  input wire flag_greater,
  input wire flag_lower
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire host = cmd_valid && !cmd_standalone;
  wire calculate_instruction = cmd_valid && cmd_code == `OPC_CALCULATE;
  wire comp = cmd_valid && cmd_code == `OPC_COMPARE;
  wire gt = $signed(accumulator) > $signed(cmd_value);
  wire lt = $signed(accumulator) < $signed(cmd_value);
  a_host_reply: assert property (host |=> reply_valid)
    else $error("no reply to host");
  a_stored_silent: assert property (
    cmd_valid && cmd_standalone |=> !reply_valid)
    else $error("reply to stored command");
  a_idle_hold: assert property (
    !cmd_valid |=> !reply_valid && $stable(accumulator))
    else $error("change without command");
  a_host_read_keep: assert property (
    host && cmd_code == `OPC_PORT_READ |=> $stable(accumulator))
    else $error("host read moved accumulator");
  a_calculate_instruction_echo: assert property (
    host && calculate_instruction |=> reply_value == $past(cmd_value))
    else $error("operand not echoed");
  a_load_op: assert property (
    calculate_instruction && cmd_type == `OP_LOAD |=> accumulator == $past(cmd_value))
    else $error("load wrong");
  a_add_op: assert property (
    calculate_instruction && cmd_type == `OP_ADD
    |=> accumulator == $past(accumulator) + $past(cmd_value))
    else $error("add wrong");
  a_equal_flag: assert property (
    comp |=> flag_equal == ($past(accumulator) == $past(cmd_value)))
    else $error("equal flag wrong");
  a_order_flags: assert property (
    comp |=> flag_greater == $past(gt) && flag_lower == $past(lt))
    else $error("order flags wrong");
  c_host_read: cover property (host && cmd_code == `OPC_PORT_READ);
  c_stored_calculate_instruction: cover property (calculate_instruction && cmd_standalone);
  c_compare: cover property (comp);
endmodule // io_alu_props
bind io_read_accumulator_alu io_alu_props i_io_alu_props (.*);

/* verif/testbench.sv */
// Purpose: Self-checking bench for the port-read unit
// Assumes: Pins held still from time zero
// Notes: Read expectations worked out from the pin values, calculate ones from a reference model except the fixed MUL product 32'h00001388
`timescale 1ns/1ps
`include "io_alu_defines.vh"
module testbench;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] gin = 8'ha5;
  reg [7:0] outs = 8'h3c;
  reg [11:0] an [0:5];
  wire cmd_valid, cmd_standalone, reply_valid;
  wire flag_zero, flag_equal, flag_greater, flag_lower;
  wire [7:0] cmd_code, cmd_type, cmd_bank, reply_status, reply_code;
  wire [31:0] cmd_value, reply_value, accumulator;
  integer error_cnt = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer i;
  host_model i_host_model (.*);
  io_read_accumulator_alu i_io_read_accumulator_alu (.*,
    .general_inputs(gin), .output_states(outs),
    .analog_capable_input_zero(an[0]), .analog_capable_input_four(an[1]),
    .supply_tenths_volt(an[2]), .temperature_a(an[3]),
    .temperature_b(an[4]), .temperature_c(an[5]));
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  task chk(input [31:0] seen, exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task rd(input s, input [7:0] t, b);
    i_host_model.send(s, `OPC_PORT_READ, t, b, 32'h0);
  endtask
  task calculate_instruction(input [7:0] t, input [31:0] v);
    i_host_model.send(1'b0, `OPC_CALCULATE, t, 8'h00, v);
  endtask
  function [31:0] ref_calculate_instruction(input [3:0] op, input signed [31:0] a, b);
    case (op)
      0: ref_calculate_instruction = a + b;
      1: ref_calculate_instruction = a - b;
      2: ref_calculate_instruction = a * b;
      3: ref_calculate_instruction = a / b;
      4: ref_calculate_instruction = a % b;
      5: ref_calculate_instruction = a & b;
      6: ref_calculate_instruction = a | b;
      7: ref_calculate_instruction = a ^ b;
      8: ref_calculate_instruction = ~a;
      default: ref_calculate_instruction = b;
    endcase
  endfunction
  initial begin
    for (i = 0; i < 6; i = i + 1) an[i] = 12'hfff - 12'(i * 46);
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys) resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (i = 0; i < 8; i = i + 1) begin
      rd(1'b0, 8'(i), `BANK_DIGITAL_IN);
      chk(reply_value, {31'h0, gin[i]});
      chk({reply_status, reply_code}, {`STATUS_OK, `OPC_PORT_READ});
      rd(1'b0, 8'(i), `BANK_OUTPUT_STATE);
      chk(reply_value, {31'h0, outs[i]});
    end
    for (i = 0; i < 6; i = i + 1) begin
      rd(1'b0, 8'(i < 2 ? i * 4 : i + 6), `BANK_ANALOG);
      chk(reply_value, {20'h0, an[i]});
    end
    chk(accumulator, `ACC_RESET);
    $display("host reads done");
    rd(1'b1, `PORT_ALL_INPUTS, `BANK_DIGITAL_IN);
    chk(accumulator, {24'h0, gin});
    rd(1'b1, `PORT_ANALOG_FOUR, `BANK_ANALOG);
    chk(accumulator, {20'h0, an[1]});
    $display("stored reads done");
    for (i = 0; i < 10; i = i + 1) begin
      calculate_instruction(`OP_LOAD, 32'hffffe4a8);
      calculate_instruction(8'(i), 32'h3);
      chk(accumulator, ref_calculate_instruction(4'(i), 32'hffffe4a8, 32'h3));
      chk(reply_value, 32'h3);
    end
    calculate_instruction(`OP_LOAD, 32'h7fffffff);
    calculate_instruction(`OP_MUL, 32'hffffec78);
    chk(accumulator, 32'h00001388);
    $display("calculate done");
    calculate_instruction(`OP_LOAD, 32'h3e8);
    for (i = 0; i < 3; i = i + 1) begin
      i_host_model.send(1'b1, `OPC_COMPARE, 8'h00, 8'h00, 32'h3e7 + i);
      chk(flag_equal, i == 1);
      chk({flag_zero, flag_greater, flag_lower}, {i==1, i==0, i==2});
    end
    i_host_model.send(1'b0, 8'h00, 8'h00, 8'h00, 32'h0);
    chk({reply_status, accumulator}, {`STATUS_BAD_CMD, 32'h3e8});
    rd(1'b1, 8'h05, `BANK_ANALOG);
    chk({reply_status, accumulator}, {`STATUS_BAD_CMD, 32'h3e8});
    rd(1'b0, 8'h00, 8'h03);
    chk({reply_status, reply_value}, {`STATUS_BAD_CMD, 32'h0});
    $display("compare done");
    wrap_up;
  end
endmodule // testbench
